/* File: pkg/iodsr_pkg.sv */
// constants for the eight-channel i/o driver register bank
// assumes a 10 mhz clk that also serves as the filter and pwm clock
package iodsr_pkg;
   // register addresses on the 5-bit bus
   localparam logic [4:0] ADDR_LEVEL     = 5'h00;
   localparam logic [4:0] ADDR_CHG_MSG   = 5'h01;
   localparam logic [4:0] ADDR_STATUS    = 5'h02;
   localparam logic [4:0] ADDR_SHORT_MSG = 5'h03;
   localparam logic [4:0] ADDR_SHORT_NOW = 5'h04;
   localparam logic [4:0] ADDR_PART      = 5'h05;
   localparam logic [4:0] ADDR_DRIVER    = 5'h06;
   localparam logic [4:0] ADDR_FLASH     = 5'h07;
   localparam logic [4:0] ADDR_CHG_MASK  = 5'h08;
   localparam logic [4:0] ADDR_SC_MASK   = 5'h09;
   localparam logic [4:0] ADDR_FILT_ACK  = 5'h0d;
   localparam logic [4:0] ADDR_PW_SEL    = 5'h0e;
   localparam logic [4:0] ADDR_PW_DUTY   = 5'h0f;
   // field positions
   localparam int ACK_BIT        = 7;
   localparam int FILT_UPPER_BIT = 4;
   localparam int BYPASS_BIT     = 3;
   localparam int FILT_LOWER_BIT = 0;
   localparam int PW_ON_BIT      = 4;
   localparam int PW_POL_BIT     = 3;
   localparam int ST_CHG_BIT     = 7;
   localparam int ST_SHUT_BIT    = 6;
   localparam int ST_WARN_BIT    = 5;
   localparam int ST_SC_BIT      = 4;
   // reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   // timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int FILT_SHORT_NS  = 2_300_000;
   localparam int FILT_LONG_NS   = 4_600_000;
   localparam int FILT_SHORT_CYC = FILT_SHORT_NS / CLK_PERIOD_NS;
   localparam int FILT_LONG_CYC  = FILT_LONG_NS / CLK_PERIOD_NS;
   localparam int PW_STEP_CYC    = 16;
   localparam logic [7:0] PW_LAST_SLOT = 8'hfe;
   localparam logic [3:0] PW_LAST_SUB  = 4'(PW_STEP_CYC - 1);
endpackage

/* File: rtl/iodsr_regs.sv */
// register bank of an eight-channel 24 v i/o driver: messages, status, pwm, masks
// assumes bus strobes and pin levels synchronous to clk; input filtering done outside
`timescale 1ns/1ps
`default_nettype none
module iodsr_regs
   import iodsr_pkg::*;
#(
   parameter int         SHORT_FILT_CYC = FILT_SHORT_CYC,
   parameter int         LONG_FILT_CYC  = FILT_LONG_CYC,
   parameter logic [5:0] PART_CODE      = 6'h2a // arbitrary value
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       supply_low,
   // processor bus
   input  wire logic       cs_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [4:0] addr,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   // pin and monitor inputs
   input  wire logic [1:0] nibble_output_mode,
   input  wire logic [7:0] sensed_level_bits,
   input  wire logic [7:0] short_raw,
   input  wire logic       temp_warn_now,
   input  wire logic       temp_shutdown_now,
   // output stage control
   output logic      [7:0] driver_on,
   output logic      [7:0] source_off,
   output logic      [7:0] flash_mask_bits,
   output logic            irq_line_n
);
   logic       rst_i;
   logic [7:0] outmask, flash_q;
   logic       rd_act, wr_act, rd_q, wr_q, rd_start, wr_start, ack;
   logic [7:0] driver_on_bits, change_irq_mask_bits, short_irq_mask_bits;
   logic [7:0] filt_ctl, pw_sel, pw_duty;
   logic [7:0] chg_msg, sc_msg, chg_pend, sc_pend;
   logic [1:0] heat_msg, heat_pend;
   logic       chg_frz, sc_frz, stat_frz;
   logic [7:0] level_q, short_filt, short_filt_q;
   logic       warn_q, shut_q;
   logic [7:0] chg_evt, sc_evt, short_now_bits;
   logic [1:0] heat_evt;
   logic [7:0] pw_slot;
   logic [3:0] pw_sub;
   logic       pwm_raw, pwm_level;
   logic [2:0] pulse_pin_select;
   logic       pulse_width_on, pulse_polarity, short_filter_bypass;
   logic [7:0] rd_mux, status_val;
   logic [7:0] next_driver, next_flash, next_chg_mask, next_sc_mask;
   logic [7:0] next_filt_ctl, next_pw_sel, next_pw_duty, next_data_out;
   logic [7:0] next_chg_msg, next_sc_msg, next_chg_pend, next_sc_pend;
   logic [1:0] next_heat_msg, next_heat_pend;
   logic       next_chg_frz, next_sc_frz, next_stat_frz;
   logic [7:0] next_pw_slot;
   logic [3:0] next_pw_sub;
   logic [15:0] filt_cnt [8];

   assign rst_i   = rst | supply_low;
   assign outmask = {{4{nibble_output_mode[1]}}, {4{nibble_output_mode[0]}}};
   assign rd_act   = !cs_n && !rd_n;
   assign wr_act   = !cs_n && !wr_n;
   assign rd_start = rd_act && !rd_q;
   assign wr_start = wr_act && !wr_q;
   assign data_oe  = rd_act;
   assign ack = wr_start && addr == ADDR_FILT_ACK && data_in[ACK_BIT];

   assign pulse_pin_select    = pw_sel[2:0];
   assign pulse_width_on      = pw_sel[PW_ON_BIT];
   assign pulse_polarity      = pw_sel[PW_POL_BIT];
   assign short_filter_bypass = filt_ctl[BYPASS_BIT];
   assign flash_mask_bits     = flash_q;

   for (genvar i = 0; i < 8; i++) begin : g_filt
      logic [15:0] lim, next_cnt;
      logic        next_filt;
      always_comb begin
         lim = (filt_ctl[(i < 4) ? FILT_LOWER_BIT : FILT_UPPER_BIT])
             ? 16'(LONG_FILT_CYC - 1) : 16'(SHORT_FILT_CYC - 1);
         next_cnt  = filt_cnt[i];
         next_filt = short_filt[i];
         if (short_filter_bypass) begin
            next_cnt  = 16'h0000;
            next_filt = short_raw[i];
         end else if (!short_raw[i]) begin
            next_cnt  = 16'h0000;
            next_filt = 1'b0;
         // at or past the limit, so a shorter length picked mid-count still releases
         end else if (filt_cnt[i] >= lim) begin
            next_filt = 1'b1;
         end else begin
            next_cnt = filt_cnt[i] + 16'h0001;
         end
      end
      always_ff @(posedge clk) begin
         if (rst_i) begin
            filt_cnt[i]   <= 16'h0000;
            short_filt[i] <= 1'b0;
         end else begin
            filt_cnt[i]   <= next_cnt;
            short_filt[i] <= next_filt;
         end
      end
   end

   assign short_now_bits = short_raw & outmask;
   // change events only for input-mode pins
   assign chg_evt  = (sensed_level_bits ^ level_q) & ~outmask & change_irq_mask_bits;
   assign sc_evt   = short_filt & ~short_filt_q & outmask & short_irq_mask_bits;
   assign heat_evt = {temp_shutdown_now & ~shut_q, temp_warn_now & ~warn_q};

   assign pwm_raw   = pw_slot < pw_duty;
   assign pwm_level = pulse_polarity ? !pwm_raw : pwm_raw;

   always_comb begin
      status_val                = REG_RESET;
      status_val[ST_CHG_BIT]    = |(chg_msg & ~outmask);
      status_val[ST_SHUT_BIT]   = heat_msg[1];
      status_val[ST_WARN_BIT]   = heat_msg[0];
      status_val[ST_SC_BIT]     = |(sc_msg & outmask);
      status_val[2]             = temp_shutdown_now;
      status_val[1]             = temp_warn_now;
      status_val[0]             = |short_now_bits;
   end

   always_comb begin
      case (addr)
         ADDR_LEVEL:     rd_mux = sensed_level_bits;
         ADDR_CHG_MSG:   rd_mux = chg_msg & ~outmask;
         ADDR_STATUS:    rd_mux = status_val;
         ADDR_SHORT_MSG: rd_mux = sc_msg & outmask;
         ADDR_SHORT_NOW: rd_mux = short_now_bits;
         ADDR_PART:      rd_mux = {2'b00, PART_CODE};
         ADDR_DRIVER:    rd_mux = driver_on_bits;
         ADDR_FLASH:     rd_mux = flash_q;
         ADDR_CHG_MASK:  rd_mux = change_irq_mask_bits;
         ADDR_SC_MASK:   rd_mux = short_irq_mask_bits;
         ADDR_FILT_ACK:  rd_mux = filt_ctl;
         ADDR_PW_SEL:    rd_mux = pw_sel;
         ADDR_PW_DUTY:   rd_mux = pw_duty;
         default:        rd_mux = REG_RESET;
      endcase
   end

   always_comb begin
      next_driver   = driver_on_bits;
      next_flash    = flash_q;
      next_chg_mask = change_irq_mask_bits;
      next_sc_mask  = short_irq_mask_bits;
      next_filt_ctl = filt_ctl;
      next_pw_sel   = pw_sel;
      next_pw_duty  = pw_duty;
      next_data_out = rd_act ? rd_mux : data_out;
      if (wr_start) begin
         case (addr)
            ADDR_DRIVER:   next_driver = data_in;
            ADDR_FLASH:    next_flash  = data_in;
            // change mask bits only take writes for input-mode nibbles
            ADDR_CHG_MASK: next_chg_mask = (data_in & ~outmask)
                                         | (change_irq_mask_bits & outmask);
            ADDR_SC_MASK:  next_sc_mask  = data_in;
            ADDR_FILT_ACK: next_filt_ctl = data_in & 8'h19;
            ADDR_PW_SEL:   next_pw_sel   = data_in & 8'h1f;
            ADDR_PW_DUTY:  next_pw_duty  = data_in;
            default:       next_driver   = driver_on_bits;
         endcase
      end
   end

   always_comb begin
      next_chg_msg   = chg_msg;
      next_sc_msg    = sc_msg;
      next_heat_msg  = heat_msg;
      next_chg_pend  = chg_pend;
      next_sc_pend   = sc_pend;
      next_heat_pend = heat_pend;
      next_chg_frz   = chg_frz;
      next_sc_frz    = sc_frz;
      next_stat_frz  = stat_frz;
      if (ack) begin
         // clear, reload from pipeline; new events are kept
         next_chg_msg   = chg_pend | chg_evt;
         next_sc_msg    = sc_pend | sc_evt;
         next_heat_msg  = heat_pend | heat_evt;
         next_chg_pend  = 8'h00;
         next_sc_pend   = 8'h00;
         next_heat_pend = 2'b00;
         next_chg_frz   = 1'b0;
         next_sc_frz    = 1'b0;
         next_stat_frz  = 1'b0;
      end else begin
         if (chg_frz) next_chg_pend = chg_pend | chg_evt;
         else         next_chg_msg  = chg_msg | chg_evt;
         if (sc_frz)  next_sc_pend  = sc_pend | sc_evt;
         else         next_sc_msg   = sc_msg | sc_evt;
         if (stat_frz) next_heat_pend = heat_pend | heat_evt;
         else          next_heat_msg  = heat_msg | heat_evt;
         if (rd_start && addr == ADDR_CHG_MSG)   next_chg_frz  = 1'b1;
         if (rd_start && addr == ADDR_SHORT_MSG) next_sc_frz   = 1'b1;
         if (rd_start && addr == ADDR_STATUS)    next_stat_frz = 1'b1;
      end
   end

   always_comb begin
      next_pw_sub  = pw_sub + 4'h1;
      next_pw_slot = pw_slot;
      if (pw_sub == PW_LAST_SUB) begin
         next_pw_sub  = 4'h0;
         next_pw_slot = (pw_slot == PW_LAST_SLOT) ? 8'h00 : pw_slot + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         driver_on_bits       <= REG_RESET;
         flash_q              <= REG_RESET;
         change_irq_mask_bits <= REG_RESET;
         short_irq_mask_bits  <= REG_RESET;
         filt_ctl             <= REG_RESET;
         pw_sel               <= REG_RESET;
         pw_duty              <= REG_RESET;
         data_out             <= REG_RESET;
         chg_msg              <= REG_RESET;
         sc_msg               <= REG_RESET;
         chg_pend             <= REG_RESET;
         sc_pend              <= REG_RESET;
         heat_msg             <= 2'b00;
         heat_pend            <= 2'b00;
         chg_frz              <= 1'b0;
         sc_frz               <= 1'b0;
         stat_frz             <= 1'b0;
         rd_q                 <= 1'b0;
         wr_q                 <= 1'b0;
         level_q              <= REG_RESET;
         short_filt_q         <= REG_RESET;
         warn_q               <= 1'b0;
         shut_q               <= 1'b0;
         pw_slot              <= 8'h00;
         pw_sub               <= 4'h0;
      end else begin
         driver_on_bits       <= next_driver;
         flash_q              <= next_flash;
         change_irq_mask_bits <= next_chg_mask;
         short_irq_mask_bits  <= next_sc_mask;
         filt_ctl             <= next_filt_ctl;
         pw_sel               <= next_pw_sel;
         pw_duty              <= next_pw_duty;
         data_out             <= next_data_out;
         chg_msg              <= next_chg_msg;
         sc_msg               <= next_sc_msg;
         chg_pend             <= next_chg_pend;
         sc_pend              <= next_sc_pend;
         heat_msg             <= next_heat_msg;
         heat_pend            <= next_heat_pend;
         chg_frz              <= next_chg_frz;
         sc_frz               <= next_sc_frz;
         stat_frz             <= next_stat_frz;
         rd_q                 <= rd_act;
         wr_q                 <= wr_act;
         level_q              <= sensed_level_bits;
         short_filt_q         <= short_filt;
         warn_q               <= temp_warn_now;
         shut_q               <= temp_shutdown_now;
         pw_slot              <= next_pw_slot;
         pw_sub               <= next_pw_sub;
      end
   end

   always_comb begin
      driver_on  = driver_on_bits & outmask;
      source_off = 8'h00;
      if (pulse_width_on) begin
         driver_on[pulse_pin_select]  = pwm_level;
         source_off[pulse_pin_select] = 1'b1;
      end
   end

   // line low while any message pending
   assign irq_line_n = !(|(chg_msg & ~outmask) || |(sc_msg & outmask) || |heat_msg);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst_i);

   sequence s_status_read;
      rd_start && addr == ADDR_STATUS;
   endsequence
   sequence s_queued_ack;
      ack && (|chg_pend || |sc_pend || |heat_pend);
   endsequence

   AST_ACK_RELOAD: assert property (ack |=> sc_msg == ($past(sc_pend) | $past(sc_evt)))
      else $error("ack did not reload short message");
   AST_FILT_LEN: assert property (!$past(short_filter_bypass) && $rose(short_filt[0])
      |-> $past(filt_cnt[0]) >= ($past(filt_ctl[FILT_LOWER_BIT])
          ? 16'(LONG_FILT_CYC - 1) : 16'(SHORT_FILT_CYC - 1)))
      else $error("filter released at wrong count");
   AST_BYPASS: assert property (short_filter_bypass |=> short_filt == $past(short_raw))
      else $error("bypass did not pass raw short");
   AST_PWM_ROUTE: assert property (pulse_width_on
      |-> driver_on[pulse_pin_select] == pwm_level && source_off[pulse_pin_select])
      else $error("pwm not routed to selected pin");
   AST_DUTY_EDGES: assert property ((pw_duty == 8'h00 |-> !pwm_raw)
      and (pw_duty == 8'hff |-> pwm_raw))
      else $error("duty edge value wrong");
   AST_FREEZE: assert property (chg_frz && !ack |=> $stable(chg_msg))
      else $error("frozen change message moved");
   AST_QUEUE_HOLD: assert property (s_queued_ack |=> !irq_line_n)
      else $error("line released with queued events");
   AST_HEAT_LOAD: assert property (ack |=> heat_msg == ($past(heat_pend) | $past(heat_evt)))
      else $error("queued heat interrupt not loaded");
   AST_LIVE_READ: assert property (s_status_read ##1 rd_act
      |-> data_out[2:0] == {$past(temp_shutdown_now), $past(temp_warn_now),
                            |$past(short_now_bits)})
      else $error("status live bits wrong");
   AST_MASK_OFF: assert property (!short_irq_mask_bits[0] && !sc_frz && !ack
      |=> sc_msg[0] == $past(sc_msg[0]))
      else $error("masked short raised message");
   AST_UV_OFF: assert property (@(posedge clk) disable iff (rst)
      supply_low |=> driver_on_bits == 8'h00 && pw_sel == 8'h00)
      else $error("undervoltage did not reset");
endmodule // iodsr_regs
`default_nettype wire

/* File: verif/io_driver_status_irq_regs_tb.sv */
// self-checking bench for the i/o driver register bank
// assumes iodsr_host drives the bus with two idle cycles between accesses
`timescale 1ns/1ps
`default_nettype none
module io_driver_status_irq_regs_tb
   import iodsr_pkg::*;
;
   localparam logic [5:0] CODE = 6'h15; // arbitrary value
   localparam int SHORT_LIM = 20;
   localparam int LONG_LIM  = 40;
   localparam logic [4:0] TA [9] = '{5'h06, 5'h07, 5'h09, 5'h0d, 5'h0e, 5'h0f, 5'h08, 5'h03, 5'h10};
   localparam logic [7:0] TD [9] = '{8'ha5, 8'h5a, 8'hc3, 8'hff, 8'he7, 8'h80, 8'hff, 8'hff, 8'hff};
   localparam logic [7:0] TE [9] = '{8'ha5, 8'h5a, 8'hc3, 8'h19, 8'h07, 8'h80, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] PS [3] = '{8'h17, 8'h17, 8'h1f};
   localparam logic [7:0] PD [3] = '{8'h00, 8'h02, 8'h02};
   localparam logic [15:0] PE [3] = '{16'h0000, 16'h0020, 16'h0fd0};
   localparam logic [7:0] FC [3] = '{8'h00, 8'h11, 8'h10};
   localparam logic [7:0] FP [3] = '{8'h01, 8'h01, 8'h10};
   logic        clk        = 1'b0;
   logic        rst        = 1'b1;
   logic        supply_low = 1'b0;
   logic [1:0]  mode       = 2'b11;
   logic [7:0]  lvl        = 8'h00;
   logic [7:0]  sraw       = 8'h00;
   logic        twarn      = 1'b0;
   logic        tshut      = 1'b0;
   wire logic   cs_n;
   wire logic   rd_n;
   wire logic   wr_n;
   wire logic [4:0] addr;
   wire logic [7:0] data_in;
   logic [7:0]  data_out;
   logic [7:0]  driver_on;
   logic [7:0]  source_off;
   logic [7:0]  flash;
   logic        data_oe;
   logic        irq_n;
   logic [7:0]  q;
   logic [15:0] n;
   int          err_count = 0;
   int          n_tests   = 0;

   always #50 clk = ~clk;

   iodsr_regs #(.SHORT_FILT_CYC(SHORT_LIM), .LONG_FILT_CYC(LONG_LIM), .PART_CODE(CODE)) DUT (
      .clk(clk), .rst(rst), .supply_low(supply_low), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .nibble_output_mode(mode), .sensed_level_bits(lvl), .short_raw(sraw),
      .temp_warn_now(twarn), .temp_shutdown_now(tshut), .driver_on(driver_on),
      .source_off(source_off), .flash_mask_bits(flash), .irq_line_n(irq_n));

   iodsr_host u_host (
      .clk(clk), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .addr(addr), .data_in(data_in));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      u_host.access(1'b0, a, 8'h00, q);
      check({8'h00, q}, {8'h00, exp});
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_host.access(1'b1, a, d, q);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk_irq(input logic lv);
      check({15'h0000, irq_n}, {15'h0000, lv});
   endtask

   // bounded wait; a bound that runs out ends the run
   task automatic wait_irq(input logic lv, input int k);
      for (int i = 0; i < k && irq_n !== lv; i++) begin
         @(posedge clk);
         #1;
      end
      chk_irq(lv);
      if (irq_n !== lv) summarize();
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 17; a++) rd(5'(a), (a == 5) ? {2'b00, CODE} : REG_RESET);
      chk_irq(1'b1);
      check({15'h0000, data_oe}, 16'h0000);
      fork
         rd(ADDR_LEVEL, 8'h00);
         begin
            repeat (2) @(posedge clk);
            #1 check({15'h0000, data_oe}, 16'h0001);
         end
      join
      check({8'h00, driver_on}, 16'h0000);
      wr(ADDR_FILT_ACK, 8'h80);
      $display("test reset done");
      for (int i = 0; i < 9; i++) wr(TA[i], TD[i]);
      for (int i = 0; i < 9; i++) rd(TA[i], TE[i]);
      check({8'h00, driver_on}, 16'h00a5);
      check({8'h00, source_off}, 16'h0000);
      wr(ADDR_DRIVER, 8'h00);
      wr(ADDR_FILT_ACK, 8'h80);
      @(posedge clk);
      lvl  <= 8'h96;
      sraw <= 8'h3c;
      cyc(SHORT_LIM + 8);
      rd(ADDR_LEVEL, 8'h96);
      rd(ADDR_SHORT_NOW, 8'h3c);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_CHG_MSG, 8'h00);
      chk_irq(1'b1);
      @(posedge clk);
      sraw <= 8'h00;
      wr(ADDR_FILT_ACK, 8'h80);
      $display("test access done");
      // pin 0 short then long, then pin 4 long on the upper select
      wr(ADDR_SC_MASK, 8'hff);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_FILT_ACK, FC[i]);
         @(posedge clk);
         sraw <= FP[i];
         cyc(((i == 0) ? SHORT_LIM : LONG_LIM) - 4);
         chk_irq(1'b1);
         wait_irq(1'b0, 12);
         rd(ADDR_SHORT_MSG, FP[i]);
         rd(ADDR_STATUS, 8'h11);
         @(posedge clk);
         sraw <= 8'h00;
         wr(ADDR_FILT_ACK, 8'h80);
         chk_irq(1'b1);
      end
      wr(ADDR_FILT_ACK, 8'h08);
      @(posedge clk);
      sraw <= 8'h01;
      wait_irq(1'b0, 4);
      rd(ADDR_SHORT_MSG, 8'h01);
      @(posedge clk);
      sraw <= 8'h03;
      cyc(3);
      rd(ADDR_SHORT_MSG, 8'h01);
      wr(ADDR_FILT_ACK, 8'h88);
      chk_irq(1'b0);
      rd(ADDR_SHORT_MSG, 8'h02);
      @(posedge clk);
      sraw <= 8'h00;
      wr(ADDR_FILT_ACK, 8'h88);
      chk_irq(1'b1);
      $display("test short done");
      @(posedge clk);
      twarn <= 1'b1;
      wait_irq(1'b0, 4);
      rd(ADDR_STATUS, 8'h22);
      @(posedge clk);
      tshut <= 1'b1;
      cyc(3);
      rd(ADDR_STATUS, 8'h26);
      wr(ADDR_FILT_ACK, 8'h80);
      chk_irq(1'b0);
      rd(ADDR_STATUS, 8'h46);
      wr(ADDR_FILT_ACK, 8'h80);
      chk_irq(1'b1);
      @(posedge clk);
      twarn <= 1'b0;
      tshut <= 1'b0;
      mode  <= 2'b01;
      wr(ADDR_CHG_MASK, 8'hff);
      rd(ADDR_CHG_MASK, 8'hf0);
      @(posedge clk);
      lvl <= 8'h87;
      wait_irq(1'b0, 4);
      rd(ADDR_CHG_MSG, 8'h10);
      rd(ADDR_STATUS, 8'h80);
      wr(ADDR_FILT_ACK, 8'h80);
      chk_irq(1'b1);
      $display("test events done");
      @(posedge clk);
      mode <= 2'b11;
      wr(ADDR_PW_DUTY, 8'hff);
      for (int p = 0; p < 8; p++) begin
         wr(ADDR_PW_SEL, 8'h10 | 8'(p));
         check({8'h00, driver_on}, 16'h0001 << p);
         check({8'h00, source_off}, 16'h0001 << p);
      end
      // one full period of 255 slots of 16 clocks
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_PW_SEL, PS[i]);
         wr(ADDR_PW_DUTY, PD[i]);
         n = 16'h0000;
         repeat (4080) begin
            @(posedge clk);
            #1 n += {15'h0000, driver_on[7]};
         end
         check(n, PE[i]);
      end
      wr(ADDR_PW_SEL, 8'h00);
      check({8'h00, source_off}, 16'h0000);
      $display("test pulse done");
      wr(ADDR_DRIVER, 8'hff);
      check({8'h00, driver_on}, 16'h00ff);
      check({8'h00, flash}, 16'h005a);
      @(posedge clk);
      supply_low <= 1'b1;
      @(posedge clk);
      supply_low <= 1'b0;
      cyc(1);
      check({8'h00, driver_on}, 16'h0000);
      check({8'h00, flash}, 16'h0000);
      rd(ADDR_DRIVER, 8'h00);
      $display("test supply done");
      summarize();
   end
endmodule // io_driver_status_irq_regs_tb
`default_nettype wire

/* File: verif/iodsr_host.sv */
// processor model for the 8-bit register bus of the i/o driver bank
// assumes a free-running clk; strobes change only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module iodsr_host (
   // clock and read data
   input  wire logic       clk,
   input  wire logic [7:0] data_out,
   // bus strobes, address and write data
   output var  logic       cs_n,
   output var  logic       rd_n,
   output var  logic       wr_n,
   output var  logic [4:0] addr,
   output var  logic [7:0] data_in
);
   initial begin
      cs_n    = 1'b1;
      rd_n    = 1'b1;
      wr_n    = 1'b1;
      addr    = 5'h1f;
      data_in = 8'h00;
   end

   // one access: hold through the taking edge and one edge more, release, then one idle cycle
   task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk);
      cs_n    <= 1'b0;
      rd_n    <= wr;
      wr_n    <= ~wr;
      addr    <= a;
      data_in <= d;
      @(posedge clk);
      #1 q = data_out;
      @(posedge clk);
      cs_n    <= 1'b1;
      rd_n    <= 1'b1;
      wr_n    <= 1'b1;
      // released address and data lines never keep the last value
      addr    <= ~a;
      data_in <= ~d;
      @(posedge clk);
   endtask
endmodule // iodsr_host
`default_nettype wire
